/* File: status_event_consts.svh */
/*
 * Shared constants for the status and event reporting block: register
 * reset values, field positions of the warning group and queue codes.
 * Assumes it is included by bare name from each design file.
 */
`ifndef STATUS_EVENT_CONSTS_SVH
`define STATUS_EVENT_CONSTS_SVH

// ----------------------------------------------------------------------
// Register widths and reset values
// ----------------------------------------------------------------------
`define SE_WIDTH          16
`define SE_WRITE_MASK     16'h7FFF
`define SE_RISE_RESET     16'h7FFF
`define SE_FALL_RESET     16'h0000
`define SE_ENABLE_RESET   16'h0000
`define SE_ZERO           16'h0000

// ----------------------------------------------------------------------
// Warning group bit positions and the mask of defined bits
// ----------------------------------------------------------------------
`define WB_EXCESS_VOLTAGE 0
`define WB_MAIN_CURRENT   1
`define WB_LOCAL_KEY      3
`define WB_THERMAL        4
`define WB_SENSE_OPEN     5
`define WB_AUX_REG_LOST   8
`define WB_REMOTE_INHIBIT 9
`define WB_REG_LOST       10
`define WB_AUX_CURRENT    12
`define WB_MEAS_OVERLOAD  14
`define WARN_DEFINED      16'h573B

// ----------------------------------------------------------------------
// Error queue
// ----------------------------------------------------------------------
`define ERR_OVERFLOW_CODE 16'hFEA2
`define ERR_NONE_CODE     16'h0000
`define ERR_QUEUE_DEPTH   8

`endif

/* File: status_event_pkg.sv */
/*
 * Types for the status and event reporting block: the command codes of
 * the programming port.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package status_event_pkg;

    // ------------------------------------------------------------------
    // Programming commands
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        CMD_NOP          = 5'h00,
        CMD_RD_OP_EVENT  = 5'h01,
        CMD_RD_OP_COND   = 5'h02,
        CMD_WR_OP_ENABLE = 5'h03,
        CMD_RD_OP_ENABLE = 5'h04,
        CMD_WR_OP_FALL   = 5'h05,
        CMD_RD_OP_FALL   = 5'h06,
        CMD_WR_OP_RISE   = 5'h07,
        CMD_RD_OP_RISE   = 5'h08,
        CMD_RD_WN_EVENT  = 5'h09,
        CMD_RD_WN_COND   = 5'h0A,
        CMD_WR_WN_ENABLE = 5'h0B,
        CMD_RD_WN_ENABLE = 5'h0C,
        CMD_WR_WN_FALL   = 5'h0D,
        CMD_RD_WN_FALL   = 5'h0E,
        CMD_WR_WN_RISE   = 5'h0F,
        CMD_RD_WN_RISE   = 5'h10,
        CMD_PRESET       = 5'h11,
        CMD_RD_ERROR     = 5'h12
    } cmd_t;

endpackage

`default_nettype wire

/* File: error_fifo.sv */
/*
 * Remote programming error queue: first in, first out, with the last
 * slot overwritten by the overflow code once the queue is full.
 * Assumes DEPTH is a power of two so the pointers wrap by themselves.
 */
`default_nettype none
`include "status_event_consts.svh"

module error_fifo #(
    parameter int WIDTH = `SE_WIDTH,
    parameter int DEPTH = `ERR_QUEUE_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] push_data,
    input  wire logic             pop,
    output logic      [WIDTH-1:0] head,
    output logic                  empty
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      count_q;
    logic             full;
    logic             push_ok;
    logic             pop_ok;
    logic [AW-1:0]    last_slot;

    // ------------------------------------------------------------------
    // Flags and strobes
    // ------------------------------------------------------------------
    assign full      = (count_q == (AW+1)'(DEPTH));
    assign empty     = (count_q == '0);
    assign push_ok   = push && !full;
    assign pop_ok    = pop && !empty;
    assign last_slot = wr_q - AW'(1);
    assign head      = mem[rd_q];

    // Storage has no reset; only pointers and fill count need a defined start
    always_ff @(posedge clk) begin
        if (push_ok) begin
            mem[wr_q] <= push_data;
        end else if (push && full) begin
            mem[last_slot] <= `ERR_OVERFLOW_CODE;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q    <= '0;
            rd_q    <= '0;
            count_q <= '0;
        end else begin
            if (push_ok) begin
                wr_q <= wr_q + AW'(1);
            end
            if (pop_ok) begin
                rd_q <= rd_q + AW'(1);
            end
            count_q <= count_q + (AW+1)'(push_ok) - (AW+1)'(pop_ok);
        end
    end

endmodule

`default_nettype wire

/* File: status_event_reporting.sv */
/*
 * Status and event reporting: activity and warning groups with
 * condition, transition filters, clear-on-read events and enable masks
 * driving two summary bits, plus the remote error queue.
 * Assumes status sources are asynchronous pins and that commands and
 * error reports come from logic on CLK.
 */
`default_nettype none
`include "status_event_consts.svh"

module status_event_reporting
    import status_event_pkg::*;
#(
    parameter int ERR_DEPTH = `ERR_QUEUE_DEPTH
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        CMD_VALID,
    input  wire logic [4:0]  CMD_OP,
    input  wire logic [15:0] CMD_DATA,
    input  wire logic [15:0] OP_COND_IN,
    input  wire logic        EXCESS_VOLTAGE_TRIP,
    input  wire logic        MAIN_EXCESS_CURRENT_TRIP,
    input  wire logic        LOCAL_KEY_PRESSED,
    input  wire logic        THERMAL_TRIP,
    input  wire logic        SENSE_LEAD_OPEN,
    input  wire logic        AUX_REGULATION_LOST,
    input  wire logic        REMOTE_INHIBIT_ACTIVE,
    input  wire logic        REGULATION_LOST,
    input  wire logic        AUX_EXCESS_CURRENT_TRIP,
    input  wire logic        MEAS_OVERLOAD,
    input  wire logic        ERR_VALID,
    input  wire logic [15:0] ERR_CODE,
    input  wire logic        ERR_FROM_PANEL,
    output logic             RESP_VALID,
    output logic      [15:0] RESP_DATA,
    output logic             RESP_NO_ERROR,
    output logic             PANEL_ERR_VALID,
    output logic      [15:0] PANEL_ERR_CODE,
    output logic             ACTIVITY_SUMMARY_BIT,
    output logic             WARNING_SUMMARY_BIT
);

    // ------------------------------------------------------------------
    // Transition filter: which condition bits changed in a passed way
    // ------------------------------------------------------------------
    function automatic logic [15:0] pass_edges(
        input logic [15:0] prev,
        input logic [15:0] cur,
        input logic [15:0] rise,
        input logic [15:0] fall
    );
        pass_edges = (prev & ~cur & fall)
                   | (~prev & cur & rise);
    endfunction

    logic [15:0] op_s1_q, op_s2_q, op_prev_q;
    logic [15:0] wn_s1_q, wn_s2_q, wn_prev_q;
    logic [15:0] wn_raw;
    logic [15:0] op_rise_q, op_fall_q, op_en_q, op_ev_q;
    logic [15:0] wn_rise_q, wn_fall_q, wn_en_q, wn_ev_q;
    logic [15:0] op_set, wn_set, op_ev_d, wn_ev_d, wdata;
    logic [15:0] resp_d, err_head;
    logic        err_empty, err_push, err_pop, panel_hit;
    logic        is_preset, rd_op_ev, rd_wn_ev, rd_err;
    logic        op_sum_d, wn_sum_d;
    cmd_t        cmd;

    // ------------------------------------------------------------------
    // Warning source map into bit weights
    // ------------------------------------------------------------------
    always_comb begin
        wn_raw                     = `SE_ZERO;
        wn_raw[`WB_EXCESS_VOLTAGE] = EXCESS_VOLTAGE_TRIP;
        wn_raw[`WB_MAIN_CURRENT]   = MAIN_EXCESS_CURRENT_TRIP;
        wn_raw[`WB_AUX_CURRENT]    = AUX_EXCESS_CURRENT_TRIP;
        wn_raw[`WB_LOCAL_KEY]      = LOCAL_KEY_PRESSED;
        wn_raw[`WB_THERMAL]        = THERMAL_TRIP;
        wn_raw[`WB_SENSE_OPEN]     = SENSE_LEAD_OPEN;
        wn_raw[`WB_AUX_REG_LOST]   = AUX_REGULATION_LOST;
        wn_raw[`WB_REMOTE_INHIBIT] = REMOTE_INHIBIT_ACTIVE;
        wn_raw[`WB_REG_LOST]       = REGULATION_LOST;
        wn_raw[`WB_MEAS_OVERLOAD]  = MEAS_OVERLOAD;
    end

    // Two-stage synchronisers; only stage two is read by logic
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            op_s1_q   <= `SE_ZERO;
            op_s2_q   <= `SE_ZERO;
            wn_s1_q   <= `SE_ZERO;
            wn_s2_q   <= `SE_ZERO;
            op_prev_q <= `SE_ZERO;
            wn_prev_q <= `SE_ZERO;
        end else begin
            op_s1_q   <= OP_COND_IN;
            op_s2_q   <= op_s1_q;
            wn_s1_q   <= wn_raw;
            wn_s2_q   <= wn_s1_q & `WARN_DEFINED;
            op_prev_q <= op_s2_q;
            wn_prev_q <= wn_s2_q;
        end
    end

    // ------------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------------
    assign cmd       = cmd_t'(CMD_VALID ? CMD_OP : CMD_NOP);
    assign wdata     = CMD_DATA & `SE_WRITE_MASK;
    assign is_preset = (cmd == CMD_PRESET);
    assign rd_op_ev  = (cmd == CMD_RD_OP_EVENT);
    assign rd_wn_ev  = (cmd == CMD_RD_WN_EVENT);
    assign rd_err    = (cmd == CMD_RD_ERROR);

    // Event capture; a new edge beats a read clear in the same cycle
    assign op_set  = pass_edges(op_prev_q, op_s2_q, op_rise_q, op_fall_q);
    assign wn_set  = pass_edges(wn_prev_q, wn_s2_q, wn_rise_q, wn_fall_q)
                   & `WARN_DEFINED;
    assign op_ev_d = (rd_op_ev ? `SE_ZERO : op_ev_q) | op_set;
    assign wn_ev_d = (rd_wn_ev ? `SE_ZERO : wn_ev_q) | wn_set;
    assign op_sum_d = |(op_ev_q & op_en_q);
    assign wn_sum_d = |(wn_ev_q & wn_en_q & `WARN_DEFINED);

    // Event registers and summaries
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            op_ev_q              <= `SE_ZERO;
            wn_ev_q              <= `SE_ZERO;
            ACTIVITY_SUMMARY_BIT <= 1'b0;
            WARNING_SUMMARY_BIT  <= 1'b0;
        end else begin
            op_ev_q              <= op_ev_d;
            wn_ev_q              <= wn_ev_d;
            ACTIVITY_SUMMARY_BIT <= op_sum_d;
            WARNING_SUMMARY_BIT  <= wn_sum_d;
        end
    end

    // ------------------------------------------------------------------
    // Filter and enable masks
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            op_rise_q <= `SE_RISE_RESET;
            op_fall_q <= `SE_FALL_RESET;
            op_en_q   <= `SE_ENABLE_RESET;
            wn_rise_q <= `SE_RISE_RESET;
            wn_fall_q <= `SE_FALL_RESET;
            wn_en_q   <= `SE_ENABLE_RESET;
        end else if (is_preset) begin
            op_rise_q <= `SE_RISE_RESET;
            op_fall_q <= `SE_FALL_RESET;
            op_en_q   <= `SE_ENABLE_RESET;
            wn_rise_q <= `SE_RISE_RESET;
            wn_fall_q <= `SE_FALL_RESET;
            wn_en_q   <= `SE_ENABLE_RESET;
        end else begin
            if (cmd == CMD_WR_OP_RISE)   op_rise_q <= wdata;
            if (cmd == CMD_WR_OP_FALL)   op_fall_q <= wdata;
            if (cmd == CMD_WR_OP_ENABLE) op_en_q   <= wdata;
            if (cmd == CMD_WR_WN_RISE)   wn_rise_q <= wdata;
            if (cmd == CMD_WR_WN_FALL)   wn_fall_q <= wdata;
            if (cmd == CMD_WR_WN_ENABLE) wn_en_q   <= wdata;
        end
    end

    // ------------------------------------------------------------------
    // Error queue; panel errors bypass it to the local display
    // ------------------------------------------------------------------
    assign err_push  = ERR_VALID && !ERR_FROM_PANEL;
    assign panel_hit = ERR_VALID && ERR_FROM_PANEL;
    assign err_pop  = rd_err;

    error_fifo #(
        .WIDTH (`SE_WIDTH),
        .DEPTH (ERR_DEPTH)
    ) u_err (
        .clk       (CLK),
        .rst       (RST),
        .push      (err_push),
        .push_data (ERR_CODE),
        .pop       (err_pop),
        .head      (err_head),
        .empty     (err_empty)
    );

    // Read answer mux; condition reads touch no state
    always_comb begin
        unique case (cmd)
            CMD_RD_OP_EVENT:  resp_d = op_ev_q;
            CMD_RD_OP_COND:   resp_d = op_s2_q;
            CMD_RD_OP_ENABLE: resp_d = op_en_q;
            CMD_RD_OP_FALL:   resp_d = op_fall_q;
            CMD_RD_OP_RISE:   resp_d = op_rise_q;
            CMD_RD_WN_EVENT:  resp_d = wn_ev_q;
            CMD_RD_WN_COND:   resp_d = wn_s2_q;
            CMD_RD_WN_ENABLE: resp_d = wn_en_q;
            CMD_RD_WN_FALL:   resp_d = wn_fall_q;
            CMD_RD_WN_RISE:   resp_d = wn_rise_q;
            CMD_RD_ERROR:     resp_d = err_empty ? `ERR_NONE_CODE
                                                 : err_head;
            default:          resp_d = `SE_ZERO;
        endcase
    end

    // Answer and panel display registers
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            RESP_VALID      <= 1'b0;
            RESP_DATA       <= `SE_ZERO;
            RESP_NO_ERROR   <= 1'b0;
            PANEL_ERR_VALID <= 1'b0;
            PANEL_ERR_CODE  <= `SE_ZERO;
        end else begin
            RESP_VALID      <= CMD_VALID;
            RESP_DATA       <= resp_d;
            RESP_NO_ERROR   <= rd_err && err_empty;
            PANEL_ERR_VALID <= panel_hit;
            PANEL_ERR_CODE  <= panel_hit ? ERR_CODE
                                         : PANEL_ERR_CODE;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    logic [15:0] op_fall_hit, op_rise_hit, op_open;
    assign op_fall_hit = op_prev_q & ~op_s2_q & op_fall_q;
    assign op_rise_hit = ~op_prev_q & op_s2_q & op_rise_q;
    assign op_open     = op_rise_q | op_fall_q;

    sequence s_warn_quiet;
        (wn_ev_q & wn_en_q) == `SE_ZERO;
    endsequence

    a_fall_edge_latch: assert property (
        op_fall_hit != `SE_ZERO |=>
            (op_ev_q & $past(op_fall_hit)) == $past(op_fall_hit))
        else $error("fall edge not latched");
    a_rise_edge_latch: assert property (
        op_rise_hit != `SE_ZERO |=>
            (op_ev_q & $past(op_rise_hit)) == $past(op_rise_hit))
        else $error("rise edge not latched");
    a_closed_never_set: assert property (
        ##1 (op_ev_q & ~$past(op_ev_q) & ~$past(op_open)) == `SE_ZERO)
        else $error("closed filter set an event");
    a_warn_read_clear: assert property (
        rd_wn_ev && wn_set == `SE_ZERO |=>
            wn_ev_q == `SE_ZERO && RESP_DATA == $past(wn_ev_q))
        else $error("warning event not cleared by read");
    a_cond_read_pure: assert property (
        cmd == CMD_RD_WN_COND && wn_set == `SE_ZERO |=> $stable(wn_ev_q))
        else $error("condition read changed events");
    a_warn_summary_drop: assert property (
        s_warn_quiet ##1 s_warn_quiet |-> !WARNING_SUMMARY_BIT)
        else $error("warning summary without enabled event");
    a_act_summary_follow: assert property (
        op_sum_d |=> ACTIVITY_SUMMARY_BIT)
        else $error("activity summary late");
    a_act_summary_drop: assert property (
        !op_sum_d |=> !ACTIVITY_SUMMARY_BIT)
        else $error("activity summary held too long");
    a_panel_bypass: assert property (
        panel_hit |=>
            PANEL_ERR_VALID && PANEL_ERR_CODE == $past(ERR_CODE))
        else $error("panel error not shown");
    a_unused_stay_zero: assert property (
        ((wn_ev_q | wn_s2_q) & ~`WARN_DEFINED) == `SE_ZERO)
        else $error("unused warning bit set");
    a_preset_loads: assert property (
        is_preset |=> op_rise_q == `SE_RISE_RESET &&
            wn_fall_q == `SE_FALL_RESET && op_en_q == `SE_ENABLE_RESET
            && wn_en_q == `SE_ENABLE_RESET)
        else $error("preset values wrong");
    a_empty_err_read: assert property (
        rd_err && err_empty |=>
            RESP_VALID && RESP_DATA == `ERR_NONE_CODE && RESP_NO_ERROR)
        else $error("empty error read wrong");

endmodule

`default_nettype wire

/* File: command_host.sv */
/*
 * Host controller model for the command port of the status block:
 * issues one command per call and captures the registered answer.
 * Assumes the block answers exactly one cycle after taking a command.
 */
`default_nettype none

module command_host (
    input  wire logic        clk,
    output logic             cmd_valid,
    output logic [4:0]       cmd_op,
    output logic [15:0]      cmd_data,
    input  wire logic        resp_valid,
    input  wire logic [15:0] resp_data,
    input  wire logic        resp_no_error
);
    timeunit 1ns;
    timeprecision 1ns;

    // ------------------------------------------------------------------
    // Idle state
    // ------------------------------------------------------------------
    initial begin
        cmd_valid = 1'b0;
        cmd_op    = 5'h00;
        cmd_data  = 16'h0000;
    end

    // ------------------------------------------------------------------
    // One command: strobe for one cycle, sample answer while it stands
    // ------------------------------------------------------------------
    // Idle bus carries the inverse, so stale data can never look valid
    task issue(input logic [4:0] op, input logic [15:0] data,
               output logic got_valid, output logic [15:0] got_data,
               output logic got_none);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_op    = op;
        cmd_data  = data;
        @(negedge clk);
        got_valid = resp_valid;
        got_data  = resp_data;
        got_none  = resp_no_error;
        cmd_valid = 1'b0;
        cmd_op    = ~op;
        cmd_data  = ~data;
    endtask
endmodule

`default_nettype wire

/* File: tb.sv */
/*
 * Self-checking bench for the status and event reporting block.
 * Assumes the command host model answers each call after one cycle.
 */
`default_nettype none

module tb
    import status_event_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clk, rst, cmd_valid, resp_valid, resp_none, last_ne;
    logic        err_valid, err_panel, panel_valid, act_sum, warn_sum;
    logic [4:0]  cmd_op;
    logic [15:0] cmd_data, resp_data, op_cond, wn, err_code, panel_code;
    int          num_errors, total_checks, i;
    logic [4:0]  rd_ops [6] = '{CMD_RD_OP_RISE, CMD_RD_OP_FALL,
        CMD_RD_OP_ENABLE, CMD_RD_WN_RISE, CMD_RD_WN_FALL, CMD_RD_WN_ENABLE};
    logic [15:0] rd_rst [6] = '{16'h7FFF, 16'h0000, 16'h0000, 16'h7FFF,
        16'h0000, 16'h0000};
    logic [15:0] wts [10] = '{16'h0001, 16'h0002, 16'h1000, 16'h0008,
        16'h0010, 16'h0020, 16'h0100, 16'h0200, 16'h0400, 16'h4000};

    // ------------------------------------------------------------------
    // Clock, design and host model
    // ------------------------------------------------------------------
    always #25 clk = ~clk;

    status_event_reporting #(.ERR_DEPTH(4)) status_event_reporting_inst (
        .CLK(clk), .RST(rst), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
        .CMD_DATA(cmd_data), .OP_COND_IN(op_cond),
        .EXCESS_VOLTAGE_TRIP(wn[0]), .MAIN_EXCESS_CURRENT_TRIP(wn[1]),
        .LOCAL_KEY_PRESSED(wn[3]), .THERMAL_TRIP(wn[4]),
        .SENSE_LEAD_OPEN(wn[5]), .AUX_REGULATION_LOST(wn[8]),
        .REMOTE_INHIBIT_ACTIVE(wn[9]), .REGULATION_LOST(wn[10]),
        .AUX_EXCESS_CURRENT_TRIP(wn[12]), .MEAS_OVERLOAD(wn[14]),
        .ERR_VALID(err_valid), .ERR_CODE(err_code),
        .ERR_FROM_PANEL(err_panel), .RESP_VALID(resp_valid),
        .RESP_DATA(resp_data), .RESP_NO_ERROR(resp_none),
        .PANEL_ERR_VALID(panel_valid), .PANEL_ERR_CODE(panel_code),
        .ACTIVITY_SUMMARY_BIT(act_sum), .WARNING_SUMMARY_BIT(warn_sum));

    command_host command_host_inst (
        .clk(clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_data(cmd_data), .resp_valid(resp_valid),
        .resp_data(resp_data), .resp_no_error(resp_none));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Every command must answer; writes answer zero
    task automatic xfer(input logic [4:0] op, input logic [15:0] data,
                        input logic [15:0] exp);
        logic        v;
        logic [15:0] rd;
        command_host_inst.issue(op, data, v, rd, last_ne);
        check({15'h0000, v}, 16'h0001);
        check(rd, exp);
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Source change needs four edges to reach the summary
    task automatic set_src(input logic [15:0] o, input logic [15:0] w);
        @(negedge clk);
        op_cond = o;
        wn      = w;
        wait_cyc(5);
    endtask

    // Error strobe for one cycle; code line inverted afterwards
    task automatic push(input logic [15:0] code, input logic panel);
        @(negedge clk);
        err_valid = 1'b1;
        err_code  = code;
        err_panel = panel;
        @(negedge clk);
        err_valid = 1'b0;
        err_code  = ~code;
    endtask

    task automatic check_defaults();
        for (int k = 0; k < 6; k++) begin
            xfer(rd_ops[k], 16'h0000, rd_rst[k]);
        end
    endtask

    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Watchdog: the sequence needs well under a thousand cycles
    // ------------------------------------------------------------------
    initial begin
        #200000;
        num_errors++;
        summarize();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        clk = 0; rst = 1; op_cond = 0; wn = 0;
        err_valid = 0; err_code = 0; err_panel = 0;
        num_errors = 0; total_checks = 0;
        repeat (4) @(negedge clk);
        rst = 0;
        check_defaults();
        xfer(CMD_RD_WN_EVENT, 16'h0000, 16'h0000);
        // Each warning source alone, through the default rise filter
        for (i = 0; i < 10; i++) begin
            set_src(16'h0000, wts[i]);
            xfer(CMD_RD_WN_COND, 16'h0000, wts[i]);
            xfer(CMD_RD_WN_COND, 16'h0000, wts[i]);
            xfer(CMD_RD_WN_EVENT, 16'h0000, wts[i]);
            xfer(CMD_RD_WN_EVENT, 16'h0000, 16'h0000);
            set_src(16'h0000, 16'h0000);
            xfer(CMD_RD_WN_EVENT, 16'h0000, 16'h0000);
        end
        // All pins high: unused positions stay clear
        set_src(16'h0000, 16'hFFFF);
        xfer(CMD_RD_WN_COND, 16'h0000, 16'h573B);
        check({15'h0000, warn_sum}, 16'h0000);
        xfer(CMD_WR_WN_ENABLE, 16'hFFFF, 16'h0000);
        wait_cyc(1);
        check({15'h0000, warn_sum}, 16'h0001);
        xfer(CMD_RD_WN_EVENT, 16'h0000, 16'h573B);
        wait_cyc(1);
        check({15'h0000, warn_sum}, 16'h0000);
        // Masked event must not reach the summary
        xfer(CMD_WR_WN_FALL, 16'h0001, 16'h0000);
        xfer(CMD_WR_WN_ENABLE, 16'h0010, 16'h0000);
        set_src(16'h0000, 16'h0000);
        check({15'h0000, warn_sum}, 16'h0000);
        xfer(CMD_RD_WN_EVENT, 16'h0000, 16'h0001);
        // Activity filters: bit0 rise, bit1 fall, bit2 both, bit3 none
        xfer(CMD_WR_OP_RISE, 16'h0005, 16'h0000);
        xfer(CMD_WR_OP_FALL, 16'h0006, 16'h0000);
        xfer(CMD_RD_OP_RISE, 16'h0000, 16'h0005);
        set_src(16'h000F, 16'h0000);
        xfer(CMD_RD_OP_COND, 16'h0000, 16'h000F);
        xfer(CMD_RD_OP_EVENT, 16'h0000, 16'h0005);
        xfer(CMD_RD_OP_EVENT, 16'h0000, 16'h0000);
        set_src(16'h0000, 16'h0000);
        xfer(CMD_WR_OP_ENABLE, 16'h0002, 16'h0000);
        wait_cyc(1);
        check({15'h0000, act_sum}, 16'h0001);
        xfer(CMD_RD_OP_EVENT, 16'h0000, 16'h0006);
        wait_cyc(1);
        check({15'h0000, act_sum}, 16'h0000);
        xfer(CMD_WR_OP_ENABLE, 16'hFFFF, 16'h0000);
        xfer(CMD_RD_OP_ENABLE, 16'h0000, 16'h7FFF);
        xfer(CMD_PRESET, 16'h0000, 16'h0000);
        check_defaults();
        // Error queue order, empty read, overflow and panel errors
        push(16'h0011, 1'b0);
        push(16'h0022, 1'b0);
        xfer(CMD_RD_ERROR, 16'h0000, 16'h0011);
        check({15'h0000, last_ne}, 16'h0000);
        xfer(CMD_RD_ERROR, 16'h0000, 16'h0022);
        xfer(CMD_RD_ERROR, 16'h0000, 16'h0000);
        check({15'h0000, last_ne}, 16'h0001);
        for (i = 1; i <= 6; i++) begin
            push(16'(i), 1'b0);
        end
        for (i = 1; i <= 3; i++) begin
            xfer(CMD_RD_ERROR, 16'h0000, 16'(i));
        end
        xfer(CMD_RD_ERROR, 16'h0000, 16'(-350));
        xfer(CMD_RD_ERROR, 16'h0000, 16'h0000);
        push(16'hFF9C, 1'b1);
        check({15'h0000, panel_valid}, 16'h0001);
        check(panel_code, 16'hFF9C);
        xfer(CMD_RD_ERROR, 16'h0000, 16'h0000);
        summarize();
    end
endmodule

`default_nettype wire
